// [design/ccr_pkg.sv]
// Constants, field positions and carrier types for the card/device control registers.
// Assumes byte-wide configuration accesses with a function number of 0 or 1.
`default_nettype none

package ccr_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CARD_CTRL_OFF = 8'h91;
  localparam logic [7:0] DEV_CTRL_OFF  = 8'h92;

  // ---------------------------------------------------------------------------
  // Card control fields
  // ---------------------------------------------------------------------------
  localparam int RING_EN_BIT   = 7;
  localparam int ZV_EN_BIT     = 6;
  localparam int PORT_SEL_BIT  = 5;
  localparam int AUD_MUX_BIT   = 2;
  localparam int CARD_SPEAKER_EN_BIT   = 1;
  localparam int IRQ_FLAG_BIT  = 0;

  localparam logic [7:0] CARD_RST         = 8'h00;
  localparam logic [7:0] CARD_GLOBAL_MASK = 8'h80;
  localparam logic [7:0] CARD_LOCAL_MASK  = 8'h67;

  // ---------------------------------------------------------------------------
  // Device control fields
  // ---------------------------------------------------------------------------
  localparam int PWR_LOCK_BIT  = 7;
  localparam int LV_FORCE_BIT  = 6;
  localparam int DIAG_BIT      = 5;
  localparam int MODE_LSB      = 1;
  localparam int MODE_MSB      = 2;

  localparam logic [7:0] DEV_RST         = 8'h66;
  localparam logic [7:0] DEV_GLOBAL_MASK = 8'h49;
  localparam logic [7:0] DEV_LOCAL_MASK  = 8'ha6;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    IRQ_PAR_PCI      = 2'b00,
    IRQ_PAR_IRQ_PCI  = 2'b01,
    IRQ_SER_IRQ_PCI  = 2'b10,
    IRQ_SER_ALL      = 2'b11
  } ccr_irq_mode_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       fn;
    logic [7:0] off;
    logic [7:0] data;
  } ccr_cfg_req_t;

endpackage : ccr_pkg

`default_nettype wire

// [design/ccr_sync2.sv]
// Two-flop synchroniser for a group of pin levels.
// Assumes each bit is an independent slow level; no bus coherency.
`default_nettype none

module ccr_sync2 #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] async,
  output var  logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      synced <= '0;
    end else begin
      meta_r <= async;
      synced <= meta_r;
    end
  end

endmodule // ccr_sync2

`default_nettype wire

// [design/ccr_socket_regs.sv]
// Per-socket copy of the non-global card and device control bits.
// Assumes the parent qualifies the request with this socket's function number.
`default_nettype none

module ccr_socket_regs (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Configuration access
  input  wire logic                 sel,
  input  wire ccr_pkg::ccr_cfg_req_t req,
  // Card event
  input  wire logic                 irqEvent,
  // Register views
  output var  logic [7:0]           cardView,
  output var  logic [7:0]           devView
);

  logic [7:0] card_r;
  logic [7:0] dev_r;
  wire        wrCard = sel & req.wr & (req.off == ccr_pkg::CARD_CTRL_OFF);
  wire        wrDev  = sel & req.wr & (req.off == ccr_pkg::DEV_CTRL_OFF);
  wire        flagClr = wrCard & req.data[ccr_pkg::IRQ_FLAG_BIT];
  // Set beats the clear so an interrupt landing on the clear is kept
  wire        flagNxt = irqEvent | (card_r[ccr_pkg::IRQ_FLAG_BIT] & ~flagClr);
  wire [7:0]  rwMask  = ccr_pkg::CARD_LOCAL_MASK & ~(8'h01 << ccr_pkg::IRQ_FLAG_BIT);
  wire [7:0]  cardNxt = wrCard ? ((req.data & rwMask) | (card_r & ~rwMask)) : card_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      card_r <= ccr_pkg::CARD_RST;
      dev_r  <= ccr_pkg::DEV_RST & ccr_pkg::DEV_LOCAL_MASK;
    end else begin
      card_r <= (cardNxt & ~8'h01) | {7'h00, flagNxt};
      if (wrDev) begin
        dev_r <= req.data & ccr_pkg::DEV_LOCAL_MASK;
      end
    end
  end

  assign cardView = card_r & ccr_pkg::CARD_LOCAL_MASK;
  assign devView  = dev_r;

endmodule // ccr_socket_regs

`default_nettype wire

// [design/ccr_control_regs.sv]
// Card control and device control registers of a two-socket card bridge.
// Assumes byte configuration accesses from the host bus logic on clk, and
// card-side pins that are asynchronous to clk.
`default_nettype none

module ccr_control_regs (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,

  // Configuration access
  input  wire ccr_pkg::ccr_cfg_req_t cfgReq,
  output var  logic [7:0]            cfgReadData,
  output var  logic                  cfgReadValid,

  // Card pins, asynchronous
  input  wire logic [1:0]            cardIrqPin,
  input  wire logic [1:0]            cardSpeaker,
  input  wire logic [1:0]            cardAudioSignal,
  input  wire logic                  ringIndicatePin,

  // Same-clock system inputs
  input  wire logic [1:0]            cardIsIoOrCardbus,
  input  wire logic                  ringPmeMuxSelect,
  input  wire logic [1:0]            powerDownRequest,
  input  wire logic [1:0]            socketInD3,

  // Ring indicate routing
  output var  logic                  ringIndicateOut,
  output var  logic                  multifunctionPin2,
  output var  logic                  multifunctionPin4,

  // Zoomed video
  output var  logic [1:0]            zoomedVideoHighZ,
  output var  logic                  videoSelectSocket0,
  output var  logic                  videoSelectSocket1,

  // Audio and speaker
  output var  logic                  cardAudioPwmFunction,
  output var  logic                  speakerOutput,
  output var  logic                  speakerOutputEn,

  // Socket configuration
  output var  logic                  lowVoltCapable,
  output var  ccr_pkg::ccr_irq_mode_t irqSignalMode0,
  output var  ccr_pkg::ccr_irq_mode_t irqSignalMode1,
  output var  logic [1:0]            socketPowerDown
);

  // ---------------------------------------------------------------------------
  // Offset decode
  // ---------------------------------------------------------------------------
  function automatic logic offHit(input logic [7:0] off, input logic [7:0] target);
    offHit = (off == target);
  endfunction

  // Unmapped offsets hit neither register and read zero
  wire cardHit  = offHit(cfgReq.off, ccr_pkg::CARD_CTRL_OFF);
  wire devHit   = offHit(cfgReq.off, ccr_pkg::DEV_CTRL_OFF);
  wire fn0Write = cfgReq.wr & ~cfgReq.fn;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Only the second flop of each bit feeds logic
  logic [6:0] pinSync;

  ccr_sync2 #(
    .WIDTH (7)
  ) u_pin_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .async  ({ringIndicatePin, cardAudioSignal, cardSpeaker, cardIrqPin}),
    .synced (pinSync)
  );

  wire [1:0] irqSync     = pinSync[1:0];
  wire [1:0] speakerSync = pinSync[3:2];
  wire [1:0] audioSync   = pinSync[5:4];
  wire       ringSync    = pinSync[6];

  // ---------------------------------------------------------------------------
  // Per-socket registers
  // ---------------------------------------------------------------------------
  logic [7:0] sockCard [2];
  logic [7:0] sockDev  [2];

  // Both copies see every request; the function number picks one
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sock
      ccr_socket_regs u_regs (
        .clk      (clk),
        .rst_n    (rst_n),
        .sel      (cfgReq.fn == 1'(s)),
        .req      (cfgReq),
        .irqEvent (irqSync[s] & cardIsIoOrCardbus[s]),
        .cardView (sockCard[s]),
        .devView  (sockDev[s])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Global bits
  // ---------------------------------------------------------------------------
  // One copy serves both functions; function 1 writes leave it alone
  logic [7:0] globCard_r;
  logic [7:0] globDev_r;

  wire wrGlobCard = fn0Write & cardHit;
  wire wrGlobDev  = fn0Write & devHit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      globCard_r <= ccr_pkg::CARD_RST & ccr_pkg::CARD_GLOBAL_MASK;
    end else if (wrGlobCard) begin
      globCard_r <= cfgReq.data & ccr_pkg::CARD_GLOBAL_MASK;
    end
  end

  // Test bits are stored as written; nonzero values are not policed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      globDev_r <= ccr_pkg::DEV_RST & ccr_pkg::DEV_GLOBAL_MASK;
    end else if (wrGlobDev) begin
      globDev_r <= cfgReq.data & ccr_pkg::DEV_GLOBAL_MASK;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Reserved bits fall out of the masks, so they always read zero
  wire [7:0] selCard  = cfgReq.fn ? sockCard[1] : sockCard[0];
  wire [7:0] selDev   = cfgReq.fn ? sockDev[1] : sockDev[0];
  wire [7:0] cardRead = selCard | globCard_r;
  wire [7:0] devRead  = selDev | globDev_r;
  wire [7:0] readNxt  = cardHit ? cardRead : (devHit ? devRead : 8'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReadValid <= 1'b0;
    end else begin
      cfgReadValid <= cfgReq.rd;
    end
  end

  // Data holds between reads; only the valid flag pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReadData <= 8'h00;
    end else if (cfgReq.rd) begin
      cfgReadData <= readNxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Ring indicate routing
  // ---------------------------------------------------------------------------
  wire ringEnable = globCard_r[ccr_pkg::RING_EN_BIT];
  wire ringGated  = ringEnable & ringSync;
  wire ringPmeNxt = ringGated & ~ringPmeMuxSelect;

  // ---------------------------------------------------------------------------
  // Zoomed video
  // ---------------------------------------------------------------------------
  wire zv0     = sockCard[0][ccr_pkg::ZV_EN_BIT];
  wire zv1     = sockCard[1][ccr_pkg::ZV_EN_BIT];
  // Priority is taken from the socket 0 copy of the select bit
  wire portSel = sockCard[0][ccr_pkg::PORT_SEL_BIT];
  wire video_select_socket0  = zv0 & ~(zv1 & portSel);
  wire video_select_socket1  = zv1 & ~(zv0 & ~portSel);

  // ---------------------------------------------------------------------------
  // Audio and speaker
  // ---------------------------------------------------------------------------
  wire aud0     = sockCard[0][ccr_pkg::AUD_MUX_BIT];
  wire aud1     = sockCard[1][ccr_pkg::AUD_MUX_BIT];
  // Socket 1 reaches the mux only while socket 0 has not claimed it
  wire audioNxt = aud0 ? audioSync[0] : (aud1 & audioSync[1]);

  wire spkEn0   = sockCard[0][ccr_pkg::CARD_SPEAKER_EN_BIT];
  wire spkEn1   = sockCard[1][ccr_pkg::CARD_SPEAKER_EN_BIT];
  // A disabled socket adds zero to the XOR
  wire spkNxt   = (spkEn0 & speakerSync[0]) ^ (spkEn1 & speakerSync[1]);
  wire spkDrive = spkEn0 | spkEn1;

  // ---------------------------------------------------------------------------
  // Socket configuration
  // ---------------------------------------------------------------------------
  wire [1:0] lock;
  assign lock[0] = sockDev[0][ccr_pkg::PWR_LOCK_BIT];
  assign lock[1] = sockDev[1][ccr_pkg::PWR_LOCK_BIT];

  // A locked socket in D3 keeps power, e.g. for wake on ring
  wire [1:0] pwrDownNxt = powerDownRequest & ~(lock & socketInD3);

  wire [1:0] mode0 = sockDev[0][ccr_pkg::MODE_MSB:ccr_pkg::MODE_LSB];
  wire [1:0] mode1 = sockDev[1][ccr_pkg::MODE_MSB:ccr_pkg::MODE_LSB];

  // ---------------------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------------------
  // One flop per pin, so a register write never glitches a terminal

  // ---------------------------------------------------------------------------
  // Ring indicate outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ringIndicateOut <= 1'b0;
    end else begin
      ringIndicateOut <= ringPmeNxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multifunctionPin2 <= 1'b0;
    end else begin
      multifunctionPin2 <= ringGated;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multifunctionPin4 <= 1'b0;
    end else begin
      multifunctionPin4 <= ringGated;
    end
  end

  // ---------------------------------------------------------------------------
  // Zoomed video outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zoomedVideoHighZ <= 2'b00;
    end else begin
      zoomedVideoHighZ <= {zv1, zv0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      videoSelectSocket0 <= 1'b0;
    end else begin
      videoSelectSocket0 <= video_select_socket0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      videoSelectSocket1 <= 1'b0;
    end else begin
      videoSelectSocket1 <= video_select_socket1;
    end
  end

  // ---------------------------------------------------------------------------
  // Audio and speaker outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cardAudioPwmFunction <= 1'b0;
    end else begin
      cardAudioPwmFunction <= audioNxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speakerOutput <= 1'b0;
    end else begin
      speakerOutput <= spkNxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speakerOutputEn <= 1'b0;
    end else begin
      speakerOutputEn <= spkDrive;
    end
  end

  // ---------------------------------------------------------------------------
  // Socket configuration outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowVoltCapable <= ccr_pkg::DEV_RST[ccr_pkg::LV_FORCE_BIT];
    end else begin
      lowVoltCapable <= globDev_r[ccr_pkg::LV_FORCE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqSignalMode0 <= ccr_pkg::IRQ_SER_ALL;
    end else begin
      irqSignalMode0 <= ccr_pkg::ccr_irq_mode_t'(mode0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqSignalMode1 <= ccr_pkg::IRQ_SER_ALL;
    end else begin
      irqSignalMode1 <= ccr_pkg::ccr_irq_mode_t'(mode1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      socketPowerDown <= 2'b00;
    end else begin
      socketPowerDown <= pwrDownNxt;
    end
  end

endmodule // ccr_control_regs

`default_nettype wire

// [verification/ccr_control_regs_props.sv]
// Port checker for the card and device control register block.
// Assumes it is bound to ccr_control_regs and sees only its ports.
`default_nettype none

module ccr_control_regs_props (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Watched ports
  input wire ccr_pkg::ccr_cfg_req_t  cfgReq,
  input wire logic [7:0]             cfgReadData,
  input wire logic                   cfgReadValid,
  input wire logic                   ringPmeMuxSelect,
  input wire logic [1:0]             powerDownRequest,
  input wire logic                   ringIndicateOut,
  input wire logic                   multifunctionPin2,
  input wire logic                   multifunctionPin4,
  input wire logic [1:0]             zoomedVideoHighZ,
  input wire logic                   videoSelectSocket0,
  input wire logic                   videoSelectSocket1,
  input wire logic                   speakerOutput,
  input wire logic                   speakerOutputEn,
  input wire logic                   lowVoltCapable,
  input wire ccr_pkg::ccr_irq_mode_t irqSignalMode0,
  input wire ccr_pkg::ccr_irq_mode_t irqSignalMode1,
  input wire logic [1:0]             socketPowerDown
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_RING_MUX: assert property (
    ringIndicateOut |-> multifunctionPin2 && !$past(ringPmeMuxSelect))
    else $error("ring output without enable or with mux set");
  AST_RING_PINS: assert property (multifunctionPin2 == multifunctionPin4)
    else $error("multifunction ring pins disagree");
  AST_VSEL_ONE: assert property (!(videoSelectSocket0 && videoSelectSocket1))
    else $error("both video selects high");
  AST_VSEL_ZV: assert property (videoSelectSocket1 |-> zoomedVideoHighZ[1])
    else $error("socket 1 selected without video enable");
  AST_CARD_SPEAKER_DRIVE: assert property (speakerOutput |-> speakerOutputEn)
    else $error("speaker data while pin undriven");
  AST_CARD_RSVD: assert property (
    cfgReadValid && $past(cfgReq.off) == ccr_pkg::CARD_CTRL_OFF |-> cfgReadData[4:3] == 2'b00)
    else $error("card control bits 4:3 read nonzero");
  AST_DEV_RSVD: assert property (
    cfgReadValid && $past(cfgReq.off) == ccr_pkg::DEV_CTRL_OFF |-> !cfgReadData[4])
    else $error("device control bit 4 read nonzero");
  AST_PWR_REQ: assert property ((socketPowerDown & ~$past(powerDownRequest)) == 2'b00)
    else $error("power down without request");
  AST_RST_DEFAULTS: assert property (
    $rose(rst_n) |-> lowVoltCapable && irqSignalMode0 == ccr_pkg::IRQ_SER_ALL &&
    irqSignalMode1 == ccr_pkg::IRQ_SER_ALL)
    else $error("reset defaults wrong");
endmodule // ccr_control_regs_props

bind ccr_control_regs ccr_control_regs_props ccr_control_regs_props_i (.clk, .rst_n, .cfgReq,
  .cfgReadData, .cfgReadValid, .ringPmeMuxSelect, .powerDownRequest, .ringIndicateOut,
  .multifunctionPin2, .multifunctionPin4, .zoomedVideoHighZ, .videoSelectSocket0,
  .videoSelectSocket1, .speakerOutput, .speakerOutputEn, .lowVoltCapable, .irqSignalMode0,
  .irqSignalMode1, .socketPowerDown);

`default_nettype wire

// [verification/ccr_card_model.sv]
// Behavioural card sockets driving the card-side pins.
// Assumes the bench sets wanted levels; pins follow at the next rising edge.
`default_nettype none

module ccr_card_model (
  // Clock
  input  wire logic       clk,
  // Wanted levels {ring, audio[1:0], speaker[1:0], irq[1:0]}
  input  wire logic [6:0] want,
  // Card pins
  output var  logic [1:0] cardIrqPin,
  output var  logic [1:0] cardSpeaker,
  output var  logic [1:0] cardAudioSignal,
  output var  logic       ringIndicatePin
);
  // Non-blocking on the rising edge, so falling-edge changes of want never race
  always @(posedge clk) begin
    {ringIndicatePin, cardAudioSignal, cardSpeaker, cardIrqPin} <= want;
  end
endmodule // ccr_card_model

`default_nettype wire

// [verification/card_device_control_regs_bench.sv]
// Self-checking bench for the card and device control registers.
// Assumes the bound port checker and the card socket model.
`default_nettype none

module card_device_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  ccr_pkg::ccr_cfg_req_t  cfgReq = '0;
  logic [6:0]             want = 7'h00;
  logic [1:0]             cardIsIoOrCardbus = 2'b01;
  logic                   ringPmeMuxSelect = 1'b0;
  logic [1:0]             powerDownRequest = 2'b00;
  logic [1:0]             socketInD3 = 2'b00;
  logic [1:0]             cardIrqPin, cardSpeaker, cardAudioSignal, zoomedVideoHighZ;
  logic [1:0]             socketPowerDown;
  logic [7:0]             cfgReadData;
  logic                   cfgReadValid, ringIndicatePin, ringIndicateOut, multifunctionPin2;
  logic                   multifunctionPin4, videoSelectSocket0, videoSelectSocket1;
  logic                   cardAudioPwmFunction, speakerOutput, speakerOutputEn, lowVoltCapable;
  ccr_pkg::ccr_irq_mode_t irqSignalMode0, irqSignalMode1;
  int                     errors = 0;
  int                     cmp_count = 0;

  always #10 clk = ~clk;

  ccr_control_regs ccr_control_regs_i (.clk, .rst_n, .cfgReq, .cfgReadData, .cfgReadValid,
    .cardIrqPin, .cardSpeaker, .cardAudioSignal, .ringIndicatePin, .cardIsIoOrCardbus,
    .ringPmeMuxSelect, .powerDownRequest, .socketInD3, .ringIndicateOut, .multifunctionPin2,
    .multifunctionPin4, .zoomedVideoHighZ, .videoSelectSocket0, .videoSelectSocket1,
    .cardAudioPwmFunction, .speakerOutput, .speakerOutputEn, .lowVoltCapable,
    .irqSignalMode0, .irqSignalMode1, .socketPowerDown);
  ccr_card_model ccr_card_model_i (.clk, .want, .cardIrqPin, .cardSpeaker, .cardAudioSignal,
    .ringIndicatePin);

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Strobe dropped a cycle early so back-to-back calls never touch it twice at once
  task automatic wr(input logic fn, input logic [7:0] off, input logic [7:0] d);
    cfgReq = '{rd: 1'b0, wr: 1'b1, fn: fn, off: off, data: d};
    wt(1);
    cfgReq.wr = 1'b0;
    wt(1);
  endtask
  task automatic rd(input logic fn, input logic [7:0] off, input logic [7:0] exp);
    cfgReq = '{rd: 1'b1, wr: 1'b0, fn: fn, off: off, data: 8'h00};
    wt(1);
    cfgReq.rd = 1'b0;
    chk("valid", {7'h00, cfgReadValid}, 8'h01);
    chk("data", cfgReadData, exp);
    wt(1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(1'b1, 8'h91, 8'h00);
    rd(1'b1, 8'h92, 8'h66);
    rd(1'b0, 8'h95, 8'h00);
    chk("lv", {7'h00, lowVoltCapable}, 8'h01);
    wr(1'b1, 8'h92, 8'h00);
    rd(1'b1, 8'h92, 8'h40);
    rd(1'b0, 8'h92, 8'h66);
    chk("mode1", {6'h00, irqSignalMode1}, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(1'b0, 8'h92, {5'b01100, m[1:0], 1'b0});
      chk("mode0", {6'h00, irqSignalMode0}, 8'(m));
    end
    wr(1'b0, 8'h92, 8'h26);
    chk("lv", {7'h00, lowVoltCapable}, 8'h00);
    wr(1'b0, 8'h92, 8'hf6);
    rd(1'b0, 8'h92, 8'he6);
    wr(1'b0, 8'h91, 8'h18);
    rd(1'b0, 8'h91, 8'h00);
  endtask
  task automatic t_ring;
    want = 7'h40;
    wr(1'b1, 8'h91, 8'h80);
    wt(4);
    chk("ring", {5'h00, ringIndicateOut, multifunctionPin2, multifunctionPin4}, 8'h00);
    wr(1'b0, 8'h91, 8'h80);
    rd(1'b1, 8'h91, 8'h80);
    chk("ring", {5'h00, ringIndicateOut, multifunctionPin2, multifunctionPin4}, 8'h07);
    ringPmeMuxSelect = 1'b1;
    wt(2);
    chk("ring", {5'h00, ringIndicateOut, multifunctionPin2, multifunctionPin4}, 8'h03);
    wr(1'b0, 8'h91, 8'h00);
    chk("ring", {5'h00, ringIndicateOut, multifunctionPin2, multifunctionPin4}, 8'h00);
  endtask
  task automatic t_audio;
    want = 7'h2c;
    wr(1'b1, 8'h91, 8'h06);
    wt(4);
    chk("aud", {7'h00, cardAudioPwmFunction}, 8'h01);
    wr(1'b0, 8'h91, 8'h06);
    chk("spk", {6'h00, speakerOutput, speakerOutputEn}, 8'h01);
    chk("aud", {7'h00, cardAudioPwmFunction}, 8'h00);
    wr(1'b1, 8'h91, 8'h00);
    chk("spk", {6'h00, speakerOutput, speakerOutputEn}, 8'h03);
    wr(1'b0, 8'h91, 8'h00);
    chk("spk", {6'h00, speakerOutput, speakerOutputEn}, 8'h00);
  endtask
  task automatic t_video;
    wr(1'b0, 8'h91, 8'h40);
    chk("zv", {4'h0, zoomedVideoHighZ, videoSelectSocket1, videoSelectSocket0}, 8'h05);
    wr(1'b1, 8'h91, 8'h40);
    chk("zv", {4'h0, zoomedVideoHighZ, videoSelectSocket1, videoSelectSocket0}, 8'h0d);
    wr(1'b0, 8'h91, 8'h60);
    chk("zv", {4'h0, zoomedVideoHighZ, videoSelectSocket1, videoSelectSocket0}, 8'h0e);
    wr(1'b0, 8'h91, 8'h00);
    wr(1'b1, 8'h91, 8'h00);
  endtask
  task automatic t_flag;
    want = 7'h03;
    wt(4);
    want = 7'h00;
    wt(4);
    rd(1'b0, 8'h91, 8'h01);
    rd(1'b1, 8'h91, 8'h00);
    wr(1'b0, 8'h91, 8'h00);
    rd(1'b0, 8'h91, 8'h01);
    wr(1'b0, 8'h91, 8'h01);
    rd(1'b0, 8'h91, 8'h00);
    cardIsIoOrCardbus = 2'b10;
    want = 7'h03;
    wt(4);
    rd(1'b1, 8'h91, 8'h01);
    rd(1'b0, 8'h91, 8'h00);
  endtask
  task automatic t_power;
    wr(1'b0, 8'h92, 8'he6);
    powerDownRequest = 2'b11;
    socketInD3 = 2'b11;
    wt(2);
    chk("pwr", {6'h00, socketPowerDown}, 8'h02);
    socketInD3 = 2'b00;
    wt(2);
    chk("pwr", {6'h00, socketPowerDown}, 8'h03);
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    wt(20);
    rst_n = 1'b1;
    t_regs();
    t_ring();
    t_audio();
    t_video();
    t_flag();
    t_power();
    end_sim();
  end
  initial begin
    #1000000;
    errors++;
    end_sim();
  end
endmodule // card_device_control_regs_bench

`default_nettype wire
